// File: hw/mad_detector.sv
// activity and inactivity detection on per-sample acceleration data
//
// How it works
// RULE1: activity only after threshold held for duration
// RULE2: absolute activity compares raw sample to threshold
// RULE3: referenced activity uses abs difference from reference
// RULE4: reference captured when activity enabled in measurement
// RULE5: linked: reference captured at inactivity detection
// RULE6: unlinked: reference captured at each activity detection
// RULE7: activity timer from one sample to 20 seconds
// RULE8: activity timer in measurement only; wake-up single sample
// RULE9: inactivity only after below threshold for duration
// RULE10: absolute inactivity needs consecutive samples all below
// RULE11: referenced inactivity uses abs difference below threshold
// RULE12: inactivity count from one to 65535 samples
// RULE13: events set status flags, optional interrupt request
// RULE14: awake bit shows moving or stationary
// RULE15: detection works in measurement and wake-up modes
// RULE16: both detectors disabled after reset; here reset leaves arming to act_enable and inact_enable, except linked mode keeps inactivity unarmed
// RULE17: unlinked: both armed, flags pending until serviced
// RULE18: host reads each flag to clear it
// RULE19: normal, low noise and ultralow noise selectable
// RULE20: linked: only one detector armed at a time
// RULE21: awake set by activity, cleared by inactivity
// RULE22: per-axis compare; activity any axis, inactivity all
`timescale 1ns/1ps
`include "mad_defines.svh"
module mad_detector #(
  parameter int AXIS_W = `MAD_AXIS_W,
  parameter int THR_W = `MAD_THR_W,
  parameter int ACT_TIME_W = `MAD_ACT_TIME_W,
  parameter int INACT_TIME_W = `MAD_INACT_TIME_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic signed [AXIS_W-1:0] x_sample,
  input wire logic signed [AXIS_W-1:0] y_sample,
  input wire logic signed [AXIS_W-1:0] z_sample,
  input wire logic measure_mode,
  input wire logic wakeup_mode,
  input wire logic act_enable,
  input wire logic inact_enable,
  input wire logic act_referenced,
  input wire logic inact_referenced,
  input wire logic link_enable,
  input wire logic [THR_W-1:0] act_threshold,
  input wire logic [THR_W-1:0] inact_threshold,
  input wire logic [ACT_TIME_W-1:0] act_time,
  input wire logic [INACT_TIME_W-1:0] inact_time,
  input wire logic act_int_enable,
  input wire logic inact_int_enable,
  input wire logic [1:0] noise_mode_sel,
  input wire logic act_flag_clear,
  input wire logic inact_flag_clear,
  output logic act_flag,
  output logic inact_flag,
  output logic awake,
  output logic act_irq,
  output logic inact_irq,
  output logic act_armed,
  output logic inact_armed,
  output mad_pkg::mad_noise_e noise_mode
);

  initial begin
    if (AXIS_W < THR_W + 1 || AXIS_W > 16)
      $error("mad_detector: axis width unsupported");
    if ((1 << ACT_TIME_W) <= `MAD_ACT_MAX_SAMPLES)
      $error("mad_detector: activity timer too narrow");
    if ((1 << INACT_TIME_W) - 1 != `MAD_INACT_MAX_SAMPLES)
      $error("mad_detector: inactivity timer must be 16 bits");
  end

  localparam int DW = AXIS_W + 1;

  logic act_flag_reg;
  logic inact_flag_reg;
  logic awake_reg;
  logic link_act_turn_reg;
  logic act_en_d_reg;
  logic [ACT_TIME_W-1:0] act_cnt_reg;
  logic [INACT_TIME_W-1:0] inact_cnt_reg;
  logic signed [AXIS_W-1:0] ref_reg [3];
  logic [1:0] noise_reg;
  logic running;
  logic [2:0] ax_act;
  logic [2:0] ax_inact;
  logic samp_act;
  logic samp_inact;
  logic act_hit;
  logic inact_hit;
  logic act_need1;
  logic ref_load;
  logic signed [AXIS_W-1:0] samp [3];

  // magnitude of the axis value, or of its offset from the reference
  function automatic logic [DW-1:0] mad_mag(
    input logic signed [AXIS_W-1:0] s,
    input logic signed [AXIS_W-1:0] r,
    input logic use_ref
  );
    logic signed [DW-1:0] d;
    d = use_ref ? (DW'(s) - DW'(r)) : DW'(s);
    mad_mag = d[DW-1] ? DW'(-d) : DW'(d);
  endfunction

  assign samp[0] = x_sample;
  assign samp[1] = y_sample;
  assign samp[2] = z_sample;
  assign running = measure_mode | wakeup_mode; // [RULE15]

  // linked mode arms one detector; unlinked arms both [RULE20] [RULE17]
  assign act_armed = act_enable & running &
    (~link_enable | link_act_turn_reg); // [RULE16]
  assign inact_armed = inact_enable & running &
    (~link_enable | ~link_act_turn_reg); // [RULE16]

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ax_act[i] = mad_mag(samp[i], ref_reg[i], act_referenced) >
        DW'(act_threshold); // [RULE2] [RULE3]
      ax_inact[i] = mad_mag(samp[i], ref_reg[i], inact_referenced) <
        DW'(inact_threshold); // [RULE11]
    end
  end

  assign samp_act = |ax_act; // [RULE22]
  assign samp_inact = &ax_inact; // [RULE22] [RULE10]

  // wake-up mode has no activity timer; zero time treated as one sample
  assign act_need1 = wakeup_mode | (act_time <= ACT_TIME_W'(1)); // [RULE8]
  assign act_hit = sample_valid & act_armed & samp_act &
    (act_need1 |
     (act_cnt_reg + ACT_TIME_W'(1) >= act_time)); // [RULE1] [RULE7]
  assign inact_hit = sample_valid & inact_armed & samp_inact &
    ((inact_time <= INACT_TIME_W'(1)) |
     (inact_cnt_reg + INACT_TIME_W'(1) >= inact_time)); // [RULE9] [RULE12]

  // activity run length; any quiet sample in measurement mode restarts it
  always_ff @(posedge ref_clk) begin
    if (rst || !act_armed || act_hit)
      act_cnt_reg <= '0;
    else if (sample_valid && measure_mode)
      act_cnt_reg <= samp_act ? act_cnt_reg + ACT_TIME_W'(1) : '0; // [RULE1]
  end

  // consecutive quiet samples only
  always_ff @(posedge ref_clk) begin
    if (rst || !inact_armed || inact_hit)
      inact_cnt_reg <= '0;
    else if (sample_valid)
      inact_cnt_reg <= samp_inact ?
        inact_cnt_reg + INACT_TIME_W'(1) : '0; // [RULE10]
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      act_en_d_reg <= 1'b0;
    else
      act_en_d_reg <= act_enable & measure_mode;
  end

  assign ref_load = (act_enable & measure_mode & ~act_en_d_reg) | // [RULE4]
    (link_enable & inact_hit) | // [RULE5]
    (~link_enable & act_hit); // [RULE6]

  // reference taken from the current sample inputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++)
        ref_reg[i] <= '0;
    end else if (ref_load) begin
      for (int i = 0; i < 3; i++)
        ref_reg[i] <= samp[i]; // [RULE4] [RULE5] [RULE6]
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_flag_reg <= 1'b0;
      inact_flag_reg <= 1'b0;
    end else begin
      act_flag_reg <= act_hit |
        (act_flag_reg & ~act_flag_clear); // [RULE13] [RULE18]
      inact_flag_reg <= inact_hit |
        (inact_flag_reg & ~inact_flag_clear); // [RULE13] [RULE18]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      awake_reg <= 1'b0;
    else if (act_hit)
      awake_reg <= 1'b1; // [RULE14] [RULE21]
    else if (inact_hit)
      awake_reg <= 1'b0; // [RULE21]
  end

  // starts by looking for activity
  always_ff @(posedge ref_clk) begin
    if (rst || !link_enable)
      link_act_turn_reg <= 1'b1;
    else if (act_hit)
      link_act_turn_reg <= 1'b0; // [RULE20]
    else if (inact_hit)
      link_act_turn_reg <= 1'b1; // [RULE20]
  end

  // noise mode only steers the analog front end, held here for it
  always_ff @(posedge ref_clk) begin
    if (rst)
      noise_reg <= `MAD_NOISE_NORMAL;
    else if (noise_mode_sel <= `MAD_NOISE_ULTRA)
      noise_reg <= noise_mode_sel; // [RULE19]
  end

  assign act_flag = act_flag_reg;
  assign inact_flag = inact_flag_reg;
  assign awake = awake_reg;
  assign act_irq = act_flag_reg & act_int_enable; // [RULE13]
  assign inact_irq = inact_flag_reg & inact_int_enable; // [RULE13]
  assign noise_mode = mad_pkg::mad_noise_e'(noise_reg);

  property p_act_flag_set;
    @(posedge ref_clk) disable iff (rst) act_hit |=> act_flag;
  endproperty
  a_act_flag_set: assert property (p_act_flag_set) // [RULE13]
    else $error("activity flag not set");

  property p_inact_flag_set;
    @(posedge ref_clk) disable iff (rst) inact_hit |=> inact_flag;
  endproperty
  a_inact_flag_set: assert property (p_inact_flag_set) // [RULE13]
    else $error("inactivity flag not set");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (rst)
      act_flag && !act_flag_clear |=> act_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [RULE17]
    else $error("activity flag dropped while pending");

  property p_awake_up;
    @(posedge ref_clk) disable iff (rst) act_hit |=> awake;
  endproperty
  a_awake_up: assert property (p_awake_up) // [RULE21]
    else $error("awake not set by activity");

  property p_awake_down;
    @(posedge ref_clk) disable iff (rst)
      inact_hit && !act_hit |=> !awake;
  endproperty
  a_awake_down: assert property (p_awake_down) // [RULE21]
    else $error("awake not cleared by inactivity");

  property p_one_armed;
    @(posedge ref_clk) disable iff (rst)
      link_enable |-> !(act_armed && inact_armed);
  endproperty
  a_one_armed: assert property (p_one_armed) // [RULE20]
    else $error("both detectors armed in linked mode");

  property p_act_needs_hit;
    @(posedge ref_clk) disable iff (rst)
      $rose(act_flag) |-> $past(sample_valid && act_armed && samp_act);
  endproperty
  a_act_needs_hit: assert property (p_act_needs_hit) // [RULE1]
    else $error("activity without qualifying sample");

  property p_inact_swap;
    @(posedge ref_clk) disable iff (rst)
      link_enable && inact_hit ##1 link_enable |-> link_act_turn_reg;
  endproperty
  a_inact_swap: assert property (p_inact_swap) // [RULE20]
    else $error("linked mode did not rearm activity");

  property p_ref_capture;
    @(posedge ref_clk) disable iff (rst)
      !link_enable && act_hit |=> ref_reg[0] == $past(x_sample);
  endproperty
  a_ref_capture: assert property (p_ref_capture) // [RULE6]
    else $error("reference not captured on activity");

  property p_inact_flag_hold;
    @(posedge ref_clk) disable iff (rst)
      inact_flag && !inact_flag_clear |=> inact_flag;
  endproperty
  a_inact_flag_hold: assert property (p_inact_flag_hold) // [RULE17]
    else $error("inactivity flag dropped while pending");

  // wake-up mode ignores the timer, so one sample must be enough
  property p_wake_single;
    @(posedge ref_clk) disable iff (rst)
      wakeup_mode && sample_valid && act_armed && samp_act |=> act_flag;
  endproperty
  a_wake_single: assert property (p_wake_single) // [RULE8]
    else $error("wake-up mode missed single-sample activity");

  property p_noise_keep;
    @(posedge ref_clk) disable iff (rst)
      noise_mode_sel == 2'h3 |=> $stable(noise_mode);
  endproperty
  a_noise_keep: assert property (p_noise_keep) // [RULE19]
    else $error("noise mode changed on an unused code");

  c_act: cover property (@(posedge ref_clk) act_hit);
  c_inact: cover property (@(posedge ref_clk) inact_hit);
  c_wake: cover property (@(posedge ref_clk) wakeup_mode && act_hit);
  c_link_cycle: cover property (@(posedge ref_clk)
    link_enable && act_hit ##[1:50] inact_hit);

endmodule // mad_detector

// File: hw/mad_defines.svh
// constants for the motion activity detector
`ifndef MAD_DEFINES_SVH
`define MAD_DEFINES_SVH
`define MAD_AXIS_W 12
`define MAD_THR_W 11
`define MAD_ACT_TIME_W 13
`define MAD_INACT_TIME_W 16
`define MAD_ACT_MAX_SEC 20
`define MAD_ODR_MAX_HZ 400
`define MAD_ACT_MAX_SAMPLES (`MAD_ACT_MAX_SEC * `MAD_ODR_MAX_HZ)
`define MAD_INACT_MAX_SAMPLES 65535
`define MAD_NOISE_NORMAL 2'h0
`define MAD_NOISE_LOW 2'h1
`define MAD_NOISE_ULTRA 2'h2
`endif

// File: hw/mad_pkg.sv
// types for the motion activity detector
package mad_pkg;
  typedef enum logic [1:0] {
    MAD_NOISE_NORMAL_M,
    MAD_NOISE_LOW_M,
    MAD_NOISE_ULTRA_M
  } mad_noise_e;
  typedef enum logic {
    MAD_REF_ABSOLUTE,
    MAD_REF_REFERENCED
  } mad_ref_e;
endpackage

// File: sim/mad_host_model.sv
// host processor model: reads each pending flag, which clears it
`timescale 1ns/1ps
module mad_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic service,
  input wire logic act_flag,
  input wire logic inact_flag,
  output logic act_flag_clear,
  output logic inact_flag_clear
);
  // one read pulse per pending flag; a held pulse would hide new events
  always_ff @(negedge ref_clk) begin
    act_flag_clear <= !rst && service && act_flag &&
      !act_flag_clear;
    inact_flag_clear <= !rst && service && inact_flag &&
      !inact_flag_clear;
  end
endmodule // mad_host_model

// File: sim/motion_activity_detector_tb_top.sv
// self-checking testbench for the motion activity detector
`timescale 1ns/1ps
module motion_activity_detector_tb_top;
  logic ref_clk = 0, rst = 1, sample_valid = 0, service = 0;
  logic signed [11:0] x_sample = 0, y_sample = 0, z_sample = 0;
  logic measure_mode = 0, wakeup_mode = 0, act_enable = 0, inact_enable = 0;
  logic act_referenced = 0, inact_referenced = 0, link_enable = 0;
  logic [10:0] act_threshold = 11'h064, inact_threshold = 11'h032;
  logic [12:0] act_time = 13'h0001;
  logic [15:0] inact_time = 16'h0001;
  logic act_int_enable = 0, inact_int_enable = 0;
  logic [1:0] noise_mode_sel = 2'h0;
  logic act_flag_clear, inact_flag_clear, act_flag, inact_flag, awake;
  logic act_irq, inact_irq, act_armed, inact_armed;
  mad_pkg::mad_noise_e noise_mode;
  int mismatches = 0, check_count = 0, cycles = 0;
  mad_detector mad_detector_i (.ref_clk, .rst, .sample_valid, .x_sample,
    .y_sample, .z_sample, .measure_mode, .wakeup_mode, .act_enable,
    .inact_enable, .act_referenced, .inact_referenced, .link_enable,
    .act_threshold, .inact_threshold, .act_time, .inact_time,
    .act_int_enable, .inact_int_enable, .noise_mode_sel, .act_flag_clear,
    .inact_flag_clear, .act_flag, .inact_flag, .awake, .act_irq,
    .inact_irq, .act_armed, .inact_armed, .noise_mode);
  mad_host_model mad_host_model_i (.ref_clk, .rst, .service, .act_flag,
    .inact_flag, .act_flag_clear, .inact_flag_clear);
  always #5 ref_clk = !ref_clk;
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic smp(input int x, input int y, input int z);
    @(negedge ref_clk);
    sample_valid = 1;
    x_sample = 12'(x);
    y_sample = 12'(y);
    z_sample = 12'(z);
    @(negedge ref_clk);
    sample_valid = 0;
  endtask
  task automatic do_reset();
    rst = 1;
    repeat (16) @(negedge ref_clk);
    rst = 0;
  endtask
  task automatic svc();
    service = 1;
    repeat (4) @(negedge ref_clk);
    service = 0;
  endtask
  task automatic s_reset();
    chk("act_flag", 0, act_flag);
    chk("inact_flag", 0, inact_flag);
    chk("act_armed", 0, act_armed);
    chk("inact_armed", 0, inact_armed);
    chk("awake", 0, awake);
  endtask
  task automatic s_act_abs();
    measure_mode = 1;
    act_enable = 1;
    act_time = 13'h0003;
    act_int_enable = 1;
    smp(200, 0, 0);
    smp(-200, 0, 0);
    smp(100, 0, 0);
    chk("act_flag", 0, act_flag);
    smp(0, 150, 0);
    smp(0, 0, -150);
    chk("act_flag", 0, act_flag);
    smp(101, 0, 0);
    chk("act_flag", 1, act_flag);
    chk("awake", 1, awake);
    chk("act_irq", 1, act_irq);
    act_int_enable = 0;
    repeat (5) @(negedge ref_clk);
    chk("act_irq", 0, act_irq);
    chk("act_flag", 1, act_flag);
    svc();
    chk("act_flag", 0, act_flag);
  endtask
  task automatic s_inact();
    act_enable = 0;
    inact_enable = 1;
    inact_time = 16'h0002;
    inact_int_enable = 1;
    smp(10, 10, 10);
    smp(10, 10, 50);
    smp(10, -10, 10);
    chk("inact_flag", 0, inact_flag);
    smp(0, 0, 0);
    chk("inact_flag", 1, inact_flag);
    chk("awake", 0, awake);
    chk("inact_irq", 1, inact_irq);
    inact_enable = 0;
    svc();
    chk("inact_flag", 0, inact_flag);
  endtask
  task automatic s_wake();
    measure_mode = 0;
    wakeup_mode = 1;
    act_enable = 1;
    smp(300, 0, 0);
    chk("act_flag", 1, act_flag);
    chk("awake", 1, awake);
    svc();
  endtask
  task automatic s_ref();
    wakeup_mode = 0;
    act_enable = 0;
    act_referenced = 1;
    act_time = 13'h0001;
    repeat (2) @(negedge ref_clk);
    x_sample = 12'h1F4;
    measure_mode = 1;
    act_enable = 1;
    smp(550, 0, 0);
    chk("act_flag", 0, act_flag);
    smp(601, 0, 0);
    chk("act_flag", 1, act_flag);
    svc();
    smp(650, 0, 0);
    chk("act_flag", 0, act_flag);
  endtask
  task automatic s_link();
    act_referenced = 0;
    link_enable = 1;
    inact_enable = 1;
    inact_time = 16'h0001;
    do_reset();
    chk("act_armed", 1, act_armed);
    chk("inact_armed", 0, inact_armed);
    smp(300, 0, 0);
    chk("act_armed", 0, act_armed);
    chk("inact_armed", 1, inact_armed);
    act_referenced = 1;
    smp(40, 0, 0);
    chk("act_armed", 1, act_armed);
    smp(130, 0, 0);
    chk("awake", 0, awake);
    smp(141, 0, 0);
    chk("awake", 1, awake);
    inact_referenced = 1;
    smp(60, 0, 0);
    chk("awake", 0, awake);
  endtask
  task automatic s_noise();
    for (int i = 0; i < 4; i++) begin
      noise_mode_sel = 2'(i);
      repeat (2) @(negedge ref_clk);
      chk("noise_mode", 16'(i == 3 ? 2 : i), 16'(noise_mode));
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    s_reset();
    s_act_abs();
    s_inact();
    s_wake();
    s_ref();
    s_link();
    s_noise();
    complete_run();
  end
endmodule // motion_activity_detector_tb_top
